// file: logic/dma_channel_transfer_path.sv
// Purpose: one channel moving data source to destination via a buffer
// Assumes: data bus answers with mem_ack_i, inputs synchronous to clk_i
// Notes: no mode sequencing, reload or arbitration here
//
// The register offsets and the Wishbone slave port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
// How it works
// - read source to buffer, then write destination
// - after transfer decide done, raise done flag
// - source and destination step independently
// - size bit clear means word, set byte
// - byte lane picked by address bit 0
// - word steps from bit 1, byte bit 0
// - countdown drops one per transfer
// - six-bit select picks one of 64 triggers
// - select writable any time
// - trigger independent of pointers
// - software request starts a transfer
// - hardware trigger also sets software request
// - accesses stay in 16-bit data space
// - shared limits bound RAM above special area
// - above upper limit flags and ends transaction
// - below lower limit flags and ends transaction
// - pending set on load, clear on store
// - null write clears pending after source write
// - stopped mid-transfer keeps pending and buffer
// - mode field hold, inc, dec, indirect hold
// - null write adds dummy source write
module dma_channel_transfer_path #(
   parameter int TRIG_W = 64
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic ce_i,
   // wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [4:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // hardware triggers
   input wire logic [TRIG_W-1:0] trig_i,
   // data bus master
   output logic mem_req_o,
   output logic mem_we_o,
   output logic [15:0] mem_addr_o,
   output logic [1:0] mem_be_o,
   output logic [15:0] mem_wdata_o,
   input wire logic [15:0] mem_rdata_i,
   input wire logic mem_ack_i,
   output logic busy_o
);
   import dma_path_pkg::*;

   typedef enum logic [1:0] {S_IDLE, S_READ, S_WRITE, S_NULL} state_t;

   function automatic logic [15:0] wmask(input logic [15:0] old,
                                         input logic [15:0] nw,
                                         input logic [1:0] be);
      wmask = {be[1] ? nw[15:8] : old[15:8], be[0] ? nw[7:0] : old[7:0]};
   endfunction : wmask

   function automatic logic [1:0] lanes(input logic byte_m,
                                        input logic a0);
      lanes = byte_m ? (a0 ? 2'b10 : 2'b01) : 2'b11;
   endfunction : lanes

   state_t state_r, state_nxt;
   logic [15:0] ctrl_r, src_r, dst_r, cnt_r, high_r, low_r, buf_r;
   logic [5:0] sel_r;
   logic done_r, lowf_r, highf_r, pend_r, trig_d_r;
   logic ack_r;
   logic [31:0] rd_r;
   logic req_r, we_r, busy_r;
   logic [15:0] addr_r, wdata_r;
   logic [1:0] be_r;

   // ------------------------------------------------------------
   // register port decode
   // ------------------------------------------------------------
   wire bus_hit = wb_cyc_i && wb_stb_i && !ack_r;
   wire wr = bus_hit && wb_we_i;
   wire [15:0] wd = wb_dat_i[15:0];
   wire [1:0] wbe = wb_sel_i[1:0];
   wire wr_ctrl = wr && (wb_adr_i == OFS_CTRL);
   wire wr_int = wr && (wb_adr_i == OFS_INT);
   wire wr_src = wr && (wb_adr_i == OFS_SRC);
   wire wr_dst = wr && (wb_adr_i == OFS_DST);
   wire wr_cnt = wr && (wb_adr_i == OFS_CNT);
   wire wr_high = wr && (wb_adr_i == OFS_HIGH);
   wire wr_low = wr && (wb_adr_i == OFS_LOW);
   wire [15:0] int_view = {pend_r, 1'b0, sel_r, highf_r, lowf_r, done_r,
                           5'h00};
   wire [15:0] rd_sel =
      (wb_adr_i == OFS_CTRL) ? ctrl_r :
      (wb_adr_i == OFS_INT) ? int_view :
      (wb_adr_i == OFS_SRC) ? src_r :
      (wb_adr_i == OFS_DST) ? dst_r :
      (wb_adr_i == OFS_CNT) ? cnt_r :
      (wb_adr_i == OFS_HIGH) ? high_r :
      (wb_adr_i == OFS_LOW) ? low_r :
      (wb_adr_i == OFS_BUF) ? buf_r : 16'h0000;

   // ------------------------------------------------------------
   // channel controls
   // ------------------------------------------------------------
   wire enabled = ctrl_r[CTRL_EN];
   wire byte_m = ctrl_r[CTRL_SIZE];
   wire null_write_mode = ctrl_r[CTRL_NULL_WRITE_MODE];
   wire [1:0] smode = ctrl_r[CTRL_SMODE +: 2];
   wire [1:0] dmode = ctrl_r[CTRL_DMODE +: 2];
   wire trig_sel = trig_i[sel_r];
   wire trig_rise = trig_sel && !trig_d_r;
   wire start = enabled && ctrl_r[CTRL_REQ] && (state_r == S_IDLE);

   // ------------------------------------------------------------
   // pointer stepping and limits
   // ------------------------------------------------------------
   logic [15:0] src_next, dst_next;
   logic src_above, src_below, dst_above, dst_below;
   pointer_step u_src_step (
      .ptr_i(src_r),
      .mode_i(smode),
      .byte_i(byte_m),
      .next_o(src_next)
   );
   pointer_step u_dst_step (
      .ptr_i(dst_r),
      .mode_i(dmode),
      .byte_i(byte_m),
      .next_o(dst_next)
   );
   limit_check u_src_lim (
      .addr_i(src_r),
      .high_i(high_r),
      .low_i(low_r),
      .above_o(src_above),
      .below_o(src_below)
   );
   limit_check u_dst_lim (
      .addr_i(dst_r),
      .high_i(high_r),
      .low_i(low_r),
      .above_o(dst_above),
      .below_o(dst_below)
   );

   // the check looks at the address of the access just finished
   wire access_done = req_r && mem_ack_i;
   wire in_read = state_r == S_READ;
   wire in_write = state_r == S_WRITE;
   wire in_null = state_r == S_NULL;
   wire cur_above = in_write ? dst_above : src_above;
   wire cur_below = in_write ? dst_below : src_below;
   wire viol = access_done && (cur_above || cur_below);
   wire xfer_end = access_done && ((in_write && !null_write_mode) || in_null);
   wire cnt_zero = cnt_r == 16'h0001;
   wire halt = !enabled;

   // lane-steered data for the access about to begin
   wire [15:0] src_addr = byte_m ? src_r : {src_r[15:1], 1'b0};
   wire [15:0] dst_addr = byte_m ? dst_r : {dst_r[15:1], 1'b0};
   wire [1:0] src_be = lanes(byte_m, src_r[0]);
   wire [1:0] dst_be = lanes(byte_m, dst_r[0]);
   wire [15:0] rd_lane = byte_m ? (src_r[0] ? {8'h00, mem_rdata_i[15:8]} :
                         {8'h00, mem_rdata_i[7:0]}) : mem_rdata_i;
   wire [15:0] wr_lane = byte_m ? {buf_r[7:0], buf_r[7:0]} : buf_r;

   // ------------------------------------------------------------
   // sequencer
   // ------------------------------------------------------------
   always_comb begin
      state_nxt = state_r;
      case (state_r)
         S_IDLE: begin
            if (start) begin
               state_nxt = S_READ;
            end
         end
         S_READ: begin
            if (access_done) begin
               state_nxt = viol ? S_IDLE : S_WRITE;
            end else if (halt) begin
               state_nxt = S_IDLE;
            end
         end
         S_WRITE: begin
            if (access_done) begin
               state_nxt = (viol || !null_write_mode) ? S_IDLE : S_NULL;
            end else if (halt) begin
               state_nxt = S_IDLE;
            end
         end
         S_NULL: begin
            if (access_done || halt) begin
               state_nxt = S_IDLE;
            end
         end
         default: begin
            state_nxt = S_IDLE;
         end
      endcase
   end

   // a bus access is launched one cycle after entering its state
   wire launch = !req_r && !halt && (in_read || in_write || in_null) &&
                 !access_done;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state_r <= S_IDLE;
      end else if (ce_i) begin
         state_r <= state_nxt;
      end
   end

   // ------------------------------------------------------------
   // data bus master
   // ------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         req_r <= 1'b0;
         we_r <= 1'b0;
         addr_r <= 16'h0000;
         be_r <= 2'b00;
         wdata_r <= 16'h0000;
      end else if (ce_i) begin
         if (access_done || halt) begin
            req_r <= 1'b0;
         end else if (launch) begin
            req_r <= 1'b1;
            we_r <= !in_read;
            // null write goes back to the source location
            addr_r <= in_write ? dst_addr : src_addr;
            be_r <= in_write ? dst_be : src_be;
            wdata_r <= wr_lane;
         end
      end
   end

   // ------------------------------------------------------------
   // channel registers
   // ------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ctrl_r <= 16'h0000;
         sel_r <= 6'h00;
         src_r <= 16'h0000;
         dst_r <= 16'h0000;
         cnt_r <= CNT_RESET;
         high_r <= HIGH_RESET;
         low_r <= LOW_RESET;
         trig_d_r <= 1'b0;
      end else if (ce_i) begin
         trig_d_r <= trig_sel;
         if (wr_ctrl) begin
            ctrl_r <= wmask(ctrl_r, wd, wbe) & CTRL_MASK;
         end
         // trigger set wins over a software write of the same cycle
         if (enabled && trig_rise) begin
            ctrl_r[CTRL_REQ] <= 1'b1;
         end else if (xfer_end) begin
            ctrl_r[CTRL_REQ] <= 1'b0;
         end
         if (viol || (xfer_end && cnt_zero)) begin
            ctrl_r[CTRL_EN] <= 1'b0;
            ctrl_r[CTRL_REQ] <= 1'b0;
         end
         if (wr_int && wbe[1]) begin
            sel_r <= wd[INT_SEL +: 6];
         end
         if (xfer_end && !viol) begin
            src_r <= src_next;
            dst_r <= dst_next;
            cnt_r <= cnt_r - 16'h0001;
         end else begin
            if (wr_src) begin
               src_r <= wmask(src_r, wd, wbe);
            end
            if (wr_dst) begin
               dst_r <= wmask(dst_r, wd, wbe);
            end
            if (wr_cnt) begin
               cnt_r <= wmask(cnt_r, wd, wbe);
            end
         end
         if (wr_high) begin
            high_r <= wmask(high_r, wd, wbe);
         end
         if (wr_low) begin
            low_r <= wmask(low_r, wd, wbe);
         end
      end
   end

   // ------------------------------------------------------------
   // buffer and flags
   // ------------------------------------------------------------
   wire clr_flags = wr_int && wbe[0];
   wire pend_clr = access_done && ((in_write && !null_write_mode) || in_null);

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         buf_r <= 16'h0000;
         pend_r <= 1'b0;
         done_r <= 1'b0;
         lowf_r <= 1'b0;
         highf_r <= 1'b0;
      end else if (ce_i) begin
         if (access_done && in_read && !viol) begin
            buf_r <= rd_lane;
            pend_r <= 1'b1;
         end else if (pend_clr) begin
            pend_r <= 1'b0;
         end
         // hardware set beats software clear in the same cycle
         done_r <= (xfer_end && cnt_zero && !viol) ||
                   (done_r && !(clr_flags && !wd[INT_DONE]));
         lowf_r <= (viol && cur_below) ||
                   (lowf_r && !(clr_flags && !wd[INT_LOW]));
         highf_r <= (viol && cur_above) ||
                    (highf_r && !(clr_flags && !wd[INT_HIGH]));
      end
   end

   // ------------------------------------------------------------
   // wishbone answer, one cycle after the strobe
   // ------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_r <= 1'b0;
         rd_r <= 32'h0000_0000;
         busy_r <= 1'b0;
      end else if (ce_i) begin
         ack_r <= bus_hit;
         rd_r <= {16'h0000, rd_sel};
         busy_r <= state_nxt != S_IDLE;
      end
   end

   assign wb_ack_o = ack_r;
   assign wb_dat_o = rd_r;
   assign mem_req_o = req_r;
   assign mem_we_o = we_r;
   assign mem_addr_o = addr_r;
   assign mem_be_o = be_r;
   assign mem_wdata_o = wdata_r;
   assign busy_o = busy_r;
endmodule : dma_channel_transfer_path
`default_nettype wire

// file: common/dma_path_pkg.sv
// Purpose: shared constants for the channel transfer path
// Assumes: classic wishbone register port, 16-bit data bus master
// Notes: register byte offsets are word aligned
package dma_path_pkg;
   // ------------------------------------------------------------
   // register map
   // ------------------------------------------------------------
   localparam logic [4:0] OFS_CTRL = 5'h00;
   localparam logic [4:0] OFS_INT = 5'h04;
   localparam logic [4:0] OFS_SRC = 5'h08;
   localparam logic [4:0] OFS_DST = 5'h0C;
   localparam logic [4:0] OFS_CNT = 5'h10;
   localparam logic [4:0] OFS_HIGH = 5'h14;
   localparam logic [4:0] OFS_LOW = 5'h18;
   localparam logic [4:0] OFS_BUF = 5'h1C;
   // ------------------------------------------------------------
   // control fields
   // ------------------------------------------------------------
   localparam int CTRL_EN = 0;
   localparam int CTRL_SIZE = 1;
   localparam int CTRL_DMODE = 4;
   localparam int CTRL_SMODE = 6;
   localparam int CTRL_REQ = 8;
   localparam int CTRL_NULL_WRITE_MODE = 10;
   localparam logic [15:0] CTRL_MASK = 16'h05F3;
   // ------------------------------------------------------------
   // interrupt register fields
   // ------------------------------------------------------------
   localparam int INT_DONE = 5;
   localparam int INT_LOW = 6;
   localparam int INT_HIGH = 7;
   localparam int INT_SEL = 8;
   localparam int INT_PEND = 15;
   localparam logic [15:0] INT_SW_MASK = 16'h3FE0;
   // ------------------------------------------------------------
   // reset values and address space
   // ------------------------------------------------------------
   localparam logic [15:0] CNT_RESET = 16'h0001;
   localparam logic [15:0] HIGH_RESET = 16'hFFFF;
   localparam logic [15:0] LOW_RESET = 16'h0800;
   localparam logic [15:0] SPECIAL_END = 16'h07FF;
   localparam logic [15:0] SPECIAL_TOP = 16'h0800;
   // ------------------------------------------------------------
   // pointer modes
   // ------------------------------------------------------------
   typedef enum logic [1:0] {
      AM_HOLD = 2'h0,
      AM_INC = 2'h1,
      AM_DEC = 2'h2,
      AM_PIA = 2'h3
   } addr_mode_t;
endpackage : dma_path_pkg

// file: logic/pointer_step.sv
// Purpose: next pointer value after one transfer
// Assumes: pure combinational
// Notes: word size keeps bit 0 clear
`timescale 1ns/1ps
`default_nettype none
module pointer_step (
   input wire logic [15:0] ptr_i,
   input wire logic [1:0] mode_i,
   input wire logic byte_i,
   output logic [15:0] next_o
);
   import dma_path_pkg::*;
   wire [15:0] step = byte_i ? 16'h0001 : 16'h0002;
   wire [15:0] base = byte_i ? ptr_i : {ptr_i[15:1], 1'b0};
   wire [15:0] inc = base + step;
   wire [15:0] dec = base - step;
   // hold and indirect both leave the pointer alone
   assign next_o = (mode_i == AM_INC) ? inc :
                   (mode_i == AM_DEC) ? dec : base;
endmodule : pointer_step
`default_nettype wire

// file: logic/limit_check.sv
// Purpose: address limit comparator for one access
// Assumes: pure combinational
// Notes: special register area is never checked against the lower limit
`timescale 1ns/1ps
`default_nettype none
module limit_check (
   input wire logic [15:0] addr_i,
   input wire logic [15:0] high_i,
   input wire logic [15:0] low_i,
   output logic above_o,
   output logic below_o
);
   import dma_path_pkg::*;
   assign above_o = addr_i > high_i;
   assign below_o = (addr_i > SPECIAL_END) && (addr_i < low_i);
endmodule : limit_check
`default_nettype wire

// file: tb/dma_path_monitor.sv
// Purpose: port checker for the channel transfer path
// Assumes: one clock, synchronous active high reset
// Notes: attached by the bind at the foot of this file
`timescale 1ns/1ps
`default_nettype none
module dma_path_monitor #(
   parameter int TRIG_W = 64
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic ce_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_ack_o,
   input wire logic mem_req_o,
   input wire logic mem_we_o,
   input wire logic [15:0] mem_addr_o,
   input wire logic [1:0] mem_be_o,
   input wire logic [15:0] mem_wdata_o,
   input wire logic [15:0] mem_rdata_i,
   input wire logic mem_ack_i,
   input wire logic busy_o
);
   // ---------
   // shadow of the holding buffer
   // ---------
   logic armed_r;
   logic [15:0] rd_val_r;
   wire logic rd_ack = mem_req_o && !mem_we_o && mem_ack_i;
   // byte loads kept replicated, the store puts them on both lanes
   wire logic [15:0] lane_val = (mem_be_o == 2'h3) ? mem_rdata_i :
      {2{mem_be_o[1] ? mem_rdata_i[15:8] : mem_rdata_i[7:0]}};
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         armed_r <= 1'b0;
         rd_val_r <= 16'h0000;
      end else if (rd_ack) begin
         armed_r <= 1'b1;
         rd_val_r <= lane_val;
      end else if (mem_req_o && mem_we_o && mem_ack_i) begin
         armed_r <= 1'b0;
      end
   end
   // ---------
   // properties
   // ---------
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);
   sequence wb_take;
      wb_cyc_i && wb_stb_i && !wb_ack_o && ce_i;
   endsequence
   // a register write in flight may legally stop the channel
   sequence load_done;
      rd_ack && !wb_stb_i;
   endsequence
   sequence store_next;
      !mem_req_o ##[1:2] ((mem_req_o && mem_we_o) || !busy_o);
   endsequence
   chk_ack_follows: assert property (wb_take |=> wb_ack_o)
      else $error("register access not answered next cycle");
   chk_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("register ack longer than one cycle");
   chk_req_stands: assert property (
      mem_req_o && !mem_ack_i && !wb_stb_i |=> mem_req_o &&
      $stable(mem_addr_o) && $stable(mem_we_o) && $stable(mem_be_o) &&
      $stable(mem_wdata_o))
      else $error("memory request changed before its answer");
   chk_req_release: assert property (mem_req_o && mem_ack_i |=> !mem_req_o)
      else $error("memory request not released after answer");
   chk_word_even: assert property (
      mem_req_o && mem_be_o == 2'h3 |-> !mem_addr_o[0])
      else $error("word access on odd address");
   chk_byte_lane: assert property (
      mem_req_o && mem_be_o != 2'h3 |->
      mem_be_o == (mem_addr_o[0] ? 2'h2 : 2'h1))
      else $error("byte lane does not match address bit 0");
   chk_load_then_store: assert property (load_done |=> store_next)
      else $error("store did not follow the load");
   chk_store_value: assert property (
      mem_req_o && mem_we_o && armed_r |-> mem_wdata_o == rd_val_r)
      else $error("stored data differs from loaded data");
   chk_busy_access: assert property (mem_req_o |-> busy_o)
      else $error("memory access while not busy");
endmodule : dma_path_monitor
bind dma_channel_transfer_path dma_path_monitor #(.TRIG_W(TRIG_W)) u_mon (
   .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .wb_cyc_i(wb_cyc_i),
   .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .mem_req_o(mem_req_o),
   .mem_we_o(mem_we_o), .mem_addr_o(mem_addr_o), .mem_be_o(mem_be_o),
   .mem_wdata_o(mem_wdata_o), .mem_rdata_i(mem_rdata_i),
   .mem_ack_i(mem_ack_i), .busy_o(busy_o));
`default_nettype wire

// file: tb/mem_model.sv
// Purpose: data space behind the channel's memory port
// Assumes: one access at a time, answer after wait_i idle cycles
// Notes: read data toggles in every cycle without a read answer
`timescale 1ns/1ps
`default_nettype none
module mem_model (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic [4:0] wait_i,
   input wire logic req_i,
   input wire logic we_i,
   input wire logic [15:0] addr_i,
   input wire logic [1:0] be_i,
   input wire logic [15:0] wdata_i,
   output logic [15:0] rdata_o,
   output logic ack_o
);
   logic [15:0] mem [0:32767];
   logic [4:0] cnt_r;
   logic [15:0] last_wa;
   int n_wr;
   // plain always: the bench presets mem directly
   always @(posedge clk_i) begin
      ack_o <= 1'b0;
      rdata_o <= ~rdata_o;
      if (rst_i) begin
         rdata_o <= 16'h5A5A;
         n_wr <= 0;
      end
      if (rst_i || !req_i || ack_o) begin
         cnt_r <= 5'h00;
      end else if (cnt_r != wait_i) begin
         cnt_r <= cnt_r + 5'h01;
      end else begin
         ack_o <= 1'b1;
         if (!we_i) begin
            rdata_o <= mem[addr_i[15:1]];
         end else begin
            if (be_i[0]) mem[addr_i[15:1]][7:0] <= wdata_i[7:0];
            if (be_i[1]) mem[addr_i[15:1]][15:8] <= wdata_i[15:8];
            n_wr <= n_wr + 1;
            last_wa <= addr_i;
         end
      end
   end
endmodule : mem_model
`default_nettype wire

// file: tb/dma_channel_transfer_path_tb.sv
// Purpose: self-checking bench for the channel transfer path
// Assumes: memory model on the data port, wishbone master tasks
// Notes: ce_i and wb_sel_i tied, everything else driven
`timescale 1ns/1ps
`default_nettype none
module dma_channel_transfer_path_tb;
   import dma_path_pkg::*;
   localparam logic [15:0] REQ = 16'h0001 << CTRL_REQ;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic cyc = 1'b0, stb = 1'b0, wwe = 1'b0;
   logic [4:0] adr = 5'h00, dly = 5'h00;
   logic [31:0] wdat = 32'h0;
   logic [63:0] trig = 64'h0;
   logic [31:0] wb_dat_o;
   logic wb_ack_o, mem_req_o, mem_we_o, mem_ack_i, busy_o;
   logic [15:0] mem_addr_o, mem_wdata_o, mem_rdata_i, q;
   logic [1:0] mem_be_o;
   int mismatches = 0, n_checks = 0, n0;
   initial forever #2.5 clk_i = ~clk_i;
   dma_channel_transfer_path DUT (
      .clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1), .wb_cyc_i(cyc),
      .wb_stb_i(stb), .wb_we_i(wwe), .wb_adr_i(adr), .wb_sel_i(4'h3),
      .wb_dat_i(wdat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
      .trig_i(trig), .mem_req_o(mem_req_o), .mem_we_o(mem_we_o),
      .mem_addr_o(mem_addr_o), .mem_be_o(mem_be_o),
      .mem_wdata_o(mem_wdata_o), .mem_rdata_i(mem_rdata_i),
      .mem_ack_i(mem_ack_i), .busy_o(busy_o));
   mem_model u_mem (
      .clk_i(clk_i), .rst_i(rst_i), .wait_i(dly), .req_i(mem_req_o),
      .we_i(mem_we_o), .addr_i(mem_addr_o), .be_i(mem_be_o),
      .wdata_i(mem_wdata_o), .rdata_o(mem_rdata_i), .ack_o(mem_ack_i));
   // ---------
   // common tasks
   // ---------
   task automatic test_done;
      $display("checks %0d mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : test_done
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      n_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task automatic wb(input logic we, input logic [4:0] a,
         input logic [15:0] d);
      int i;
      @(posedge clk_i);
      cyc <= 1'b1;
      stb <= 1'b1;
      wwe <= we;
      adr <= a;
      wdat <= {16'h0000, d};
      i = 0;
      do begin
         @(posedge clk_i);
         i++;
      end while (wb_ack_o !== 1'b1 && i < 20);
      q = wb_dat_o[15:0];
      cyc <= 1'b0;
      stb <= 1'b0;
      if (i >= 20) begin
         mismatches++;
         test_done();
      end
   endtask : wb
   task automatic rdc(input logic [4:0] a, input logic [15:0] exp);
      wb(1'b0, a, 16'h0000);
      chk(q, exp);
   endtask : rdc
   // the hang guard waits out the slowest memory answer
   task automatic idle;
      int i;
      repeat (3) @(posedge clk_i);
      for (i = 0; i < 400 && busy_o !== 1'b0; i++) @(posedge clk_i);
      if (i >= 400) begin
         mismatches++;
         test_done();
      end
   endtask : idle
   function automatic logic [15:0] cw(input logic sz, input logic [1:0] sm,
         input logic [1:0] dm, input logic nw);
      cw = 16'h0001 | (16'(sz) << CTRL_SIZE) | (16'(dm) << CTRL_DMODE) |
         (16'(sm) << CTRL_SMODE) | (16'(nw) << CTRL_NULL_WRITE_MODE);
   endfunction : cw
   task automatic setup(input logic [15:0] s, input logic [15:0] d,
         input logic [15:0] c, input logic [15:0] ctl);
      n0 = u_mem.n_wr;
      wb(1'b1, OFS_SRC, s);
      wb(1'b1, OFS_DST, d);
      wb(1'b1, OFS_CNT, c);
      wb(1'b1, OFS_CTRL, ctl | REQ);
   endtask : setup
   task automatic xfer(input logic [15:0] s, input logic [15:0] d,
         input logic [15:0] c, input logic [15:0] ctl);
      setup(s, d, c, ctl);
      idle();
   endtask : xfer
   // ---------
   // scenarios
   // ---------
   task automatic t_reset;
      logic [4:0] ofs [8] = '{OFS_CTRL, OFS_INT, OFS_SRC, OFS_DST, OFS_CNT,
         OFS_HIGH, OFS_LOW, OFS_BUF};
      logic [15:0] rv [8] = '{16'h0000, 16'h0000, 16'h0000, 16'h0000,
         CNT_RESET, HIGH_RESET, LOW_RESET, 16'h0000};
      wb(1'b1, OFS_BUF, 16'hBEEF);
      wb(1'b1, 5'h1E, 16'hBEEF);
      foreach (ofs[i]) rdc(ofs[i], rv[i]);
      rdc(5'h1E, 16'h0000);
      $display("reset values done");
   endtask : t_reset
   task automatic t_word;
      u_mem.mem[16'h0480] = 16'hC3A5;
      xfer(16'h0900, 16'h0A00, 16'h0002, cw(1'b0, AM_INC, AM_DEC, 1'b0));
      chk(u_mem.mem[16'h0500], 16'hC3A5);
      rdc(OFS_SRC, 16'h0902);
      rdc(OFS_DST, 16'h09FE);
      rdc(OFS_CNT, 16'h0001);
      rdc(OFS_INT, 16'h0000);
      rdc(OFS_CTRL, cw(1'b0, AM_INC, AM_DEC, 1'b0));
      $display("word transfer done");
   endtask : t_word
   task automatic t_byte;
      u_mem.mem[16'h0480] = 16'hA55A;
      u_mem.mem[16'h0580] = 16'h1234;
      xfer(16'h0901, 16'h0B00, 16'h0001, cw(1'b1, AM_DEC, AM_INC, 1'b0));
      chk(u_mem.mem[16'h0580], 16'h12A5);
      rdc(OFS_SRC, 16'h0900);
      rdc(OFS_DST, 16'h0B01);
      rdc(OFS_CNT, 16'h0000);
      rdc(OFS_INT, 16'h0001 << INT_DONE);
      rdc(OFS_CTRL, cw(1'b1, AM_DEC, AM_INC, 1'b0) & 16'hFFFE);
      wb(1'b1, OFS_INT, 16'h0000);
      for (int m = 0; m < 4; m += 3) begin
         xfer(16'h0900, 16'h0A00, 16'h0002, cw(1'b0, 2'(m), 2'(3 - m), 1'b0));
         rdc(OFS_SRC, 16'h0900);
         rdc(OFS_DST, 16'h0A00);
      end
      xfer(16'h0900, 16'h0A00, 16'h0002, cw(1'b0, AM_INC, AM_INC, 1'b1));
      chk(16'(u_mem.n_wr - n0), 16'h0002);
      chk(u_mem.last_wa, 16'h0900);
      rdc(OFS_INT, 16'h0000);
      $display("byte, mode and null write done");
   endtask : t_byte
   task automatic t_limit;
      wb(1'b1, OFS_HIGH, 16'h0C00);
      xfer(16'h0D00, 16'h0A00, 16'h0002, cw(1'b0, AM_INC, AM_INC, 1'b0));
      wb(1'b0, OFS_INT, 16'h0000);
      chk(q & 16'h00E0, 16'h0001 << INT_HIGH);
      chk(16'(u_mem.n_wr - n0), 16'h0000);
      rdc(OFS_SRC, 16'h0D00);
      wb(1'b1, OFS_INT, 16'h0000);
      wb(1'b1, OFS_HIGH, 16'hFFFF);
      wb(1'b1, OFS_LOW, 16'h0900);
      xfer(16'h0A00, 16'h0850, 16'h0002, cw(1'b0, AM_INC, AM_INC, 1'b0));
      wb(1'b0, OFS_INT, 16'h0000);
      chk(q & 16'h00E0, 16'h0001 << INT_LOW);
      chk(16'(u_mem.n_wr - n0), 16'h0001);
      u_mem.mem[16'h0080] = 16'h0F0F;
      u_mem.mem[16'h0081] = 16'hF0F0;
      wb(1'b1, OFS_INT, 16'h0000);
      xfer(16'h0100, 16'h0A00, 16'h0002, cw(1'b0, AM_INC, AM_INC, 1'b0));
      rdc(OFS_SRC, 16'h0102);
      wb(1'b1, OFS_LOW, LOW_RESET);
      $display("address limits done");
   endtask : t_limit
   task automatic t_trig;
      int k [3] = '{0, 37, 63};
      dly <= 5'h06;
      wb(1'b1, OFS_CNT, 16'h0008);
      foreach (k[i]) begin
         n0 = u_mem.n_wr;
         wb(1'b1, OFS_INT, 16'(k[i]) << INT_SEL);
         wb(1'b1, OFS_CTRL, cw(1'b0, AM_HOLD, AM_HOLD, 1'b0));
         trig <= 64'h1 << (k[i] ^ 1);
         repeat (4) @(posedge clk_i);
         chk({15'h0, busy_o}, 16'h0000);
         trig <= 64'h1 << k[i];
         repeat (2) @(posedge clk_i);
         wb(1'b0, OFS_CTRL, 16'h0000);
         chk({15'h0, q[CTRL_REQ]}, 16'h0001);
         idle();
         trig <= 64'h0;
         chk(16'(u_mem.n_wr - n0), 16'h0001);
      end
      $display("triggers done");
   endtask : t_trig
   task automatic t_stop;
      int i;
      dly <= 5'h14;
      u_mem.mem[16'h0480] = 16'h6E3C;
      u_mem.mem[16'h0500] = 16'h0000;
      setup(16'h0900, 16'h0A00, 16'h0002, cw(1'b0, AM_INC, AM_INC, 1'b0));
      for (i = 0; i < 100 && !(mem_ack_i === 1'b1 && mem_we_o === 1'b0); i++)
         @(posedge clk_i);
      if (i >= 100) begin
         mismatches++;
         test_done();
      end
      wb(1'b1, OFS_CTRL, 16'h0000);
      repeat (4) @(posedge clk_i);
      wb(1'b0, OFS_INT, 16'h0000);
      chk({15'h0, q[INT_PEND]}, 16'h0001);
      rdc(OFS_BUF, 16'h6E3C);
      chk(u_mem.mem[16'h0500], 16'h0000);
      $display("stop between load and store done");
   endtask : t_stop
   initial begin
      repeat (8) @(posedge clk_i);
      rst_i <= 1'b0;
      t_reset();
      t_word();
      t_byte();
      t_limit();
      t_trig();
      t_stop();
      test_done();
   end
endmodule : dma_channel_transfer_path_tb
`default_nettype wire
